// *** event_aggregator_pkg.sv ***
package event_aggregator_pkg;

  localparam int EV_IDX_W   = 3;
  localparam int NUM_STATUS = 8;
  localparam int COUNT_W    = 16;

  localparam logic [NUM_STATUS-1:0] STATUS_RST = 8'h00;
  localparam logic [COUNT_W-1:0]    COUNT_RST  = 16'h0000;
  localparam logic [COUNT_W-1:0]    COUNT_MAX  = 16'hFFFF;

  typedef enum logic [1:0] {
    DEST_STATUS,
    DEST_SPLIT,
    DEST_COUNT,
    DEST_EXT
  } dest_t;

  typedef struct packed {
    dest_t                dest;
    logic [EV_IDX_W-1:0]  idx;
  } event_t;

  typedef enum logic [1:0] {
    SPLIT_IDLE,
    SPLIT_FIRST,
    SPLIT_SECOND
  } split_state_t;

endpackage

// *** event_counter.sv ***
`timescale 1ns/10ps
`default_nettype none
module event_counter
  import event_aggregator_pkg::*;
#(
  parameter int WIDTH = COUNT_W
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic             inc_valid,
  output logic                  inc_ready,
  input  wire logic             dec_valid,
  output logic                  dec_ready,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      count
);

  logic             taken_inc;
  logic             taken_dec;
  logic [WIDTH-1:0] next_count;

  // Both ports stall while a transition event waits
  assign inc_ready = !out_valid;
  assign dec_ready = !out_valid;
  assign taken_inc = inc_valid && inc_ready;
  assign taken_dec = dec_valid && dec_ready;

  // Saturates rather than wrapping, so a wrap cannot fake a transition
  always_comb begin
    next_count = count;
    if (taken_inc && !taken_dec && count != WIDTH'(COUNT_MAX)) begin
      next_count = count + WIDTH'(1);
    end else if (taken_dec && !taken_inc && count != WIDTH'(COUNT_RST)) begin
      next_count = count - WIDTH'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      count <= WIDTH'(COUNT_RST);
    end else begin
      count <= next_count;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      out_valid <= 1'b0;
    end else if (out_valid && out_ready) begin
      out_valid <= 1'b0;
    end else if ((count == WIDTH'(COUNT_RST)) != (next_count == WIDTH'(COUNT_RST))) begin
      out_valid <= 1'b1;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_count_edge_only: assert property (
    $rose(out_valid) |-> (($past(count) == '0) != (count == '0)))
    else $error("count event without zero transition");
  a_count_quiet: assert property (
    (!out_valid && (count == '0) == (next_count == '0)) |=> !out_valid)
    else $error("count event on plain increment");
  a_count_stall: assert property (
    out_valid && !out_ready |=> !inc_ready && $stable(count))
    else $error("counter took input while blocked");
  a_count_step: assert property (
    taken_inc && !taken_dec && count != '1 |=> count == $past(count) + WIDTH'(1))
    else $error("count did not advance");

endmodule
`default_nettype wire

// *** event_aggregator.sv ***
`timescale 1ns/10ps
`default_nettype none
module event_aggregator
  import event_aggregator_pkg::*;
(
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  input  wire logic                  ev_in_valid,
  input  wire event_t                ev_in,
  output logic                       ev_in_ready,
  output logic                       ev_out_valid,
  output event_t                     ev_out,
  input  wire logic                  ev_out_ready,
  input  wire event_t                split_route_a,
  input  wire event_t                split_route_b,
  input  wire event_t                count_route,
  input  wire logic [NUM_STATUS-1:0] status_clear,
  output logic [NUM_STATUS-1:0]      irq,
  input  wire logic                  count_dec,
  output logic [COUNT_W-1:0]         count_value,
  output logic                       route_error
);

  split_state_t split_state;
  logic         in_full;
  event_t       in_ev;
  logic         out_free;
  logic         cnt_out_valid;
  logic         cnt_in_ready;
  logic         dec_pending;
  logic         dec_ready;
  logic         split_busy;
  event_t       split_ev;
  logic         cnt_bad_route;
  logic         gnt_cnt;
  logic         gnt_split;
  logic         gnt_in;
  logic         win_valid;
  event_t       win_ev;
  logic         win_status;
  logic         win_split;
  logic         win_count;
  logic         win_ext;
  logic         next_in_full;

  // Whether the sink named by an event can take it this cycle
  function automatic logic sink_ok(input event_t e, input split_state_t st,
                                   input logic cnt_rdy, input logic ext_rdy);
    logic ok;
    ok = 1'b0;
    unique case (e.dest)
      DEST_STATUS: ok = 1'b1; // Status never blocks, so paths can unwind
      DEST_SPLIT:  ok = (st == SPLIT_IDLE);
      DEST_COUNT:  ok = cnt_rdy;
      DEST_EXT:    ok = ext_rdy;
    endcase
    return ok;
  endfunction

  assign out_free   = !ev_out_valid || ev_out_ready;
  assign split_busy = (split_state != SPLIT_IDLE);
  assign split_ev   = (split_state == SPLIT_FIRST) ? split_route_a : split_route_b;

  // A counter event aimed at the splitter is dropped and flagged
  assign cnt_bad_route = (count_route.dest == DEST_SPLIT);

  // Downstream outputs first, so pending events drain before new input
  assign gnt_cnt   = cnt_out_valid
                     && (cnt_bad_route
                         || sink_ok(count_route, split_state, cnt_in_ready, out_free));
  assign gnt_split = !gnt_cnt && split_busy
                     && sink_ok(split_ev, split_state, cnt_in_ready, out_free);
  assign gnt_in    = !gnt_cnt && !gnt_split && in_full
                     && sink_ok(in_ev, split_state, cnt_in_ready, out_free);

  assign win_valid = gnt_cnt || gnt_split || gnt_in;
  assign win_ev    = gnt_cnt ? count_route : (gnt_split ? split_ev : in_ev);

  assign win_status = win_valid && win_ev.dest == DEST_STATUS;
  assign win_split  = win_valid && win_ev.dest == DEST_SPLIT && !gnt_cnt;
  assign win_count  = win_valid && win_ev.dest == DEST_COUNT;
  assign win_ext    = win_valid && win_ev.dest == DEST_EXT;

  // Single-entry input hold; ready is registered to keep the port a flop
  assign next_in_full = (in_full && !gnt_in) || (ev_in_valid && ev_in_ready);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      in_full     <= 1'b0;
      ev_in_ready <= 1'b0;
    end else begin
      in_full     <= next_in_full;
      ev_in_ready <= !next_in_full;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      in_ev <= '0;
    end else if (ev_in_valid && ev_in_ready) begin
      in_ev <= ev_in;
    end
  end

  // Status bits: set wins over a same-cycle clear
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      irq <= STATUS_RST;
    end else begin
      for (int i = 0; i < NUM_STATUS; i++) begin
        if (win_status && win_ev.idx == EV_IDX_W'(i)) begin
          irq[i] <= 1'b1;
        end else if (status_clear[i]) begin
          irq[i] <= 1'b0;
        end
      end
    end
  end

  // Splitter refuses further split events until both outputs leave
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      split_state <= SPLIT_IDLE;
    end else begin
      unique case (split_state)
        SPLIT_IDLE:   if (win_split) split_state <= SPLIT_FIRST;
        SPLIT_FIRST:  if (gnt_split) split_state <= SPLIT_SECOND;
        SPLIT_SECOND: if (gnt_split) split_state <= SPLIT_IDLE;
        default:      split_state <= SPLIT_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ev_out_valid <= 1'b0;
      ev_out       <= '0;
    end else if (win_ext) begin
      ev_out_valid <= 1'b1;
      ev_out       <= win_ev;
    end else if (ev_out_ready) begin
      ev_out_valid <= 1'b0;
    end
  end

  // Software decrement request is held until the counter takes it
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      dec_pending <= 1'b0;
    end else if (count_dec) begin
      dec_pending <= 1'b1;
    end else if (dec_ready) begin
      dec_pending <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      route_error <= 1'b0;
    end else begin
      route_error <= gnt_cnt && cnt_bad_route;
    end
  end

  event_counter #(
    .WIDTH (COUNT_W)
  ) u_counter (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .inc_valid (win_count),
    .inc_ready (cnt_in_ready),
    .dec_valid (dec_pending),
    .dec_ready (dec_ready),
    .out_valid (cnt_out_valid),
    .out_ready (gnt_cnt),
    .count     (count_value)
  );

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence split_taken;
    win_split ##1 split_state == SPLIT_FIRST;
  endsequence

  // Second output leaves, then the splitter is free again
  sequence split_two_out;
    gnt_split && split_state == SPLIT_SECOND ##1 split_state == SPLIT_IDLE;
  endsequence

  a_split_fanout: assert property (
    win_split |-> split_taken)
    else $error("splitter did not enter first output");
  a_split_done: assert property (
    split_state == SPLIT_SECOND && gnt_split |-> split_two_out)
    else $error("splitter did not return to idle");
  a_split_second: assert property (
    split_state == SPLIT_FIRST && gnt_split |=> split_state == SPLIT_SECOND)
    else $error("splitter skipped second output");
  a_split_stall: assert property (
    split_busy && !gnt_split |=> split_busy && !$past(win_split))
    else $error("splitter took input while blocked");
  a_no_count_split: assert property (
    gnt_cnt |-> !win_split)
    else $error("counter event reached splitter");
  a_status_set: assert property (
    win_status |=> irq[$past(win_ev.idx)])
    else $error("status bit not set by event");
  a_status_hold: assert property (
    1'b1 |=> (irq & $past(irq & ~status_clear)) == $past(irq & ~status_clear))
    else $error("status bit dropped without clear");
  a_one_route: assert property (
    $onehot0({gnt_cnt, gnt_split, gnt_in}))
    else $error("event routed twice in one cycle");
  a_in_ready: assert property (
    in_full && !gnt_in |=> !ev_in_ready)
    else $error("input ready while holding event");
  a_out_hold: assert property (
    ev_out_valid && !ev_out_ready |=> ev_out_valid && $stable(ev_out))
    else $error("output event dropped while stalled");

endmodule
`default_nettype wire

// *** event_sink_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module event_sink_model
  import event_aggregator_pkg::*;
(
  input  wire logic   clk_sys,
  input  wire logic   rst_n,
  input  wire logic   stall,
  input  wire logic   ev_out_valid,
  input  wire event_t ev_out,
  output logic        ev_out_ready
);
  event_t got[$];

  initial ev_out_ready = 1'b0;

  // Sampled at the edge, ready moved just after it to keep clear of races
  always @(posedge clk_sys) begin
    if (rst_n === 1'b1 && ev_out_valid === 1'b1 && ev_out_ready === 1'b1) begin
      got.push_back(ev_out);
    end
    #1 ev_out_ready = rst_n & !stall;
  end
endmodule
`default_nettype wire

// *** event_aggregator_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
module event_aggregator_bench
  import event_aggregator_pkg::*;
();
  logic                  clk_sys;
  logic                  rst_n;
  logic                  ev_in_valid;
  event_t                ev_in;
  logic                  ev_in_ready;
  logic                  ev_out_valid;
  event_t                ev_out;
  logic                  ev_out_ready;
  event_t                split_route_a;
  event_t                split_route_b;
  event_t                count_route;
  logic [NUM_STATUS-1:0] status_clear;
  logic [NUM_STATUS-1:0] irq;
  logic                  count_dec;
  logic [COUNT_W-1:0]    count_value;
  logic                  route_error;
  logic                  stall;
  logic [NUM_STATUS-1:0] exp_irq;
  int                    n_mismatch;
  int                    n_tests;
  int                    cycles;
  int                    n_rerr;

  event_aggregator DUT (.clk_sys(clk_sys), .rst_n(rst_n), .ev_in_valid(ev_in_valid),
    .ev_in(ev_in), .ev_in_ready(ev_in_ready), .ev_out_valid(ev_out_valid), .ev_out(ev_out),
    .ev_out_ready(ev_out_ready), .split_route_a(split_route_a), .split_route_b(split_route_b),
    .count_route(count_route), .status_clear(status_clear), .irq(irq), .count_dec(count_dec),
    .count_value(count_value), .route_error(route_error));

  event_sink_model sink (.clk_sys(clk_sys), .rst_n(rst_n), .stall(stall),
    .ev_out_valid(ev_out_valid), .ev_out(ev_out), .ev_out_ready(ev_out_ready));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic summarize();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Hang guard, well above the 120 or so cycles the run needs
  always @(posedge clk_sys) begin
    cycles++;
    if (route_error === 1'b1) n_rerr++;
    if (cycles == 20000) begin
      n_mismatch++;
      summarize();
    end
  end

  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_ev(input event_t got, input event_t exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // Offer one event, hold it until an edge sees ready high
  task automatic send_ev(input dest_t d, input logic [2:0] i);
    int n;
    n = 0;
    ev_in_valid = 1'b1;
    ev_in = '{dest: d, idx: i};
    while (ev_in_ready !== 1'b1 && n < 50) begin
      tick(1);
      n++;
    end
    check_val(16'(n < 50), 16'h0001);
    tick(1);
    // Idle cycle, so a following call never rewrites valid in one step
    ev_in_valid = 1'b0;
    tick(1);
  endtask

  task automatic pop_check(input dest_t d, input logic [2:0] i);
    int n;
    n = 0;
    while (sink.got.size() == 0 && n < 50) begin
      tick(1);
      n++;
    end
    check_val(16'(sink.got.size() != 0), 16'h0001);
    if (sink.got.size() != 0) check_ev(sink.got.pop_front(), '{dest: d, idx: i});
  endtask

  task automatic test_status();
    exp_irq = 8'h00;
    for (int i = 0; i < NUM_STATUS; i++) begin
      send_ev(DEST_STATUS, 3'(i));
      tick(2);
      exp_irq[i] = 1'b1;
      check_val(16'(irq), 16'(exp_irq));
    end
    tick(10);
    check_val(16'(irq), 16'h00FF);
    status_clear = 8'h0F;
    tick(1);
    status_clear = 8'h00;
    tick(1);
    check_val(16'(irq), 16'h00F0);
    status_clear = 8'hF0;
    tick(1);
    status_clear = 8'h00;
    tick(1);
    check_val(16'(irq), 16'h0000);
  endtask

  task automatic test_split();
    send_ev(DEST_SPLIT, 3'h0);
    pop_check(DEST_EXT, 3'h1);
    pop_check(DEST_EXT, 3'h2);
    tick(5);
    check_val(16'(sink.got.size()), 16'h0000);
  endtask

  task automatic test_count();
    send_ev(DEST_COUNT, 3'h0);
    pop_check(DEST_EXT, 3'h3);
    tick(2);
    check_val(count_value, 16'h0001);
    send_ev(DEST_COUNT, 3'h0);
    tick(4);
    check_val(count_value, 16'h0002);
    check_val(16'(sink.got.size()), 16'h0000);
    for (int k = 0; k < 2; k++) begin
      count_dec = 1'b1;
      tick(1);
      count_dec = 1'b0;
      tick(4);
    end
    check_val(count_value, 16'h0000);
    pop_check(DEST_EXT, 3'h3);
  endtask

  // Sink held off: second event waits in the slot, input refused meanwhile
  task automatic test_stall();
    stall = 1'b1;
    send_ev(DEST_EXT, 3'h4);
    send_ev(DEST_EXT, 3'h5);
    tick(8);
    check_val(16'(ev_in_ready), 16'h0000);
    check_val(16'(ev_out_valid), 16'h0001);
    check_ev(ev_out, '{dest: DEST_EXT, idx: 3'h4});
    check_val(16'(sink.got.size()), 16'h0000);
    stall = 1'b0;
    pop_check(DEST_EXT, 3'h4);
    pop_check(DEST_EXT, 3'h5);
    tick(2);
    check_val(16'(ev_in_ready), 16'h0001);
  endtask

  // Deliberate breach of the routing convention
  task automatic test_bad_route();
    count_route = '{dest: DEST_SPLIT, idx: 3'h0};
    n_rerr = 0;
    send_ev(DEST_COUNT, 3'h0);
    tick(6);
    check_val(16'(n_rerr), 16'h0001);
    check_val(16'(sink.got.size()), 16'h0000);
  endtask

  initial begin
    rst_n = 1'b0;
    ev_in_valid = 1'b0;
    ev_in = '{dest: DEST_STATUS, idx: 3'h0};
    split_route_a = '{dest: DEST_EXT, idx: 3'h1};
    split_route_b = '{dest: DEST_EXT, idx: 3'h2};
    count_route = '{dest: DEST_EXT, idx: 3'h3};
    status_clear = 8'h00;
    count_dec = 1'b0;
    stall = 1'b0;
    n_mismatch = 0;
    n_tests = 0;
    cycles = 0;
    n_rerr = 0;
    tick(12);
    rst_n = 1'b1;
    tick(2);
    test_status();
    test_split();
    test_count();
    test_stall();
    test_bad_route();
    summarize();
  end
endmodule
`default_nettype wire
